// >>> rtl/motion_pause_cancel_status.sv
// How it works
// RL1 - status bit 12 reports that the servo may be switched on
// RL2 - status bit 13 reports that the motor is energized
// RL3 - three 4-bit monitor selections echo into status bits 16-27
// RL4 - pause halts motion yet keeps processing state for a later resume
// RL5 - pause acts only on the six motion commands; otherwise done flag stays 0
// RL6 - master sets stop mode and pause or cancel with an eligible motion command
// RL7 - stop follows the stop mode; deceleration uses the command's slowdown rate
// RL8 - pause done once pause and standstill; profile done held 0 while paused
// RL9 - master repeats the motion command until the done flag reads 1
// RL10 - clearing pause resumes the suspended motion
// RL11 - cancel discards processing state; valid for the same six commands
// RL12 - cancel done on profile done (position) or standstill (speed)
// RL13 - cancel ignored for ineligible commands; its done flag stays 0
// RL14 - cancel wins over pause, together or later
// RL15 - after cancel clears, the next motion command starts fresh
// RL16 - requests sampled and flags updated once per communication cycle
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
module motion_pause_cancel_status #(
  parameter int COMM_CYCLE_CLKS_P = motion_pause_pkg::COMM_CYCLE_CLKS
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // motion core status
  input  wire logic        standstillFlag,
  input  wire logic        profileOutputDone,
  input  wire logic        servoReadyIn,
  input  wire logic        motorEnergizedIn,
  input  wire logic        positionMode,
  // motion core control
  output logic             motionStart,
  output logic             motionDiscard,
  output logic             motionHalt,
  output logic             stopModeOut,
  output logic [31:0]      slowdownRate,
  output logic [7:0]       activeCommand,
  output logic             commTick,
  // response flags and interrupt
  output logic             suspendDoneFlag,
  output logic             abortDoneFlag,
  output logic             irq
);
  import motion_pause_pkg::*;

  localparam int CW = $clog2(COMM_CYCLE_CLKS_P + 1);

  function automatic logic isMotionCmd(input logic [7:0] code);
    isMotionCmd = (code == CMD_TARGET_MOVE) || (code == CMD_JOG_FEED) ||
                  (code == CMD_EXT_TRIGGER_JOG) || (code == CMD_EXT_TRIGGER_MOVE) ||
                  (code == CMD_HOMING) || (code == CMD_SPEED_REGULATION);
  endfunction : isMotionCmd

  function automatic logic regHit(input logic ok, input logic [7:0] a, input logic [7:0] off);
    regHit = ok && (a == off);
  endfunction : regHit

  // reset release
  logic rstSync1_r;
  logic rstSync2_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end
  wire logic rstnInt = rstSync2_r;

  // communication cycle divider
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  always_comb begin
    commTick = (cnt_r == CW'(COMM_CYCLE_CLKS_P - 1));
    cnt_nxt  = commTick ? '0 : cnt_r + CW'(1);
  end
  always_ff @(posedge clock or negedge rstnInt) begin
    if (!rstnInt) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // bus address phase
  logic       wrPend_r;
  logic       wrPend_nxt;
  logic       addrOk_r;
  logic       addrOk_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic       addrPhase;
  always_comb begin
    addrPhase  = hsel && hready && htrans[1];
    wrPend_nxt = addrPhase && hwrite;
    addrOk_nxt = addrOk_r;
    addr_nxt   = addr_r;
    if (addrPhase) begin
      addrOk_nxt = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0) &&
                   (hsize == 3'h2);
      addr_nxt   = haddr[7:0];
    end
  end
  always_ff @(posedge clock or negedge rstnInt) begin
    if (!rstnInt) begin
      wrPend_r <= 1'b0;
      addrOk_r <= 1'b0;
      addr_r   <= 8'h00;
    end else begin
      wrPend_r <= wrPend_nxt;
      addrOk_r <= addrOk_nxt;
      addr_r   <= addr_nxt;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // motion state and response flags
  motion_state_t      state_r;
  motion_state_t      state_nxt;
  logic               suspendDone_r;
  logic               suspendDone_nxt;
  logic               abortDone_r;
  logic               abortDone_nxt;
  logic [IRQ_W-1:0]   irqEvent;

  // software registers
  logic [CMD_W-1:0]    cmdReg_r;
  logic [CMD_W-1:0]    cmdReg_nxt;
  logic [MONSEL_W-1:0] monSel_r;
  logic [MONSEL_W-1:0] monSel_nxt;
  logic [31:0]         decel_r;
  logic [31:0]         decel_nxt;
  logic [IRQ_W-1:0]    irqMask_r;
  logic [IRQ_W-1:0]    irqMask_nxt;
  logic [IRQ_W-1:0]    irqStat_r;
  logic [IRQ_W-1:0]    irqStat_nxt;
  logic [IRQ_W-1:0]    irqClr;
  always_comb begin
    cmdReg_nxt  = cmdReg_r;
    monSel_nxt  = monSel_r;
    decel_nxt   = decel_r;
    irqMask_nxt = irqMask_r;
    irqClr      = '0;
    if (wrPend_r) begin
      if (regHit(addrOk_r, addr_r, ADDR_CMD)) begin
        cmdReg_nxt = hwdata[CMD_W-1:0];
      end else if (regHit(addrOk_r, addr_r, ADDR_MONSEL)) begin
        monSel_nxt = hwdata[MONSEL_W-1:0];
      end else if (regHit(addrOk_r, addr_r, ADDR_DECEL)) begin
        decel_nxt = hwdata;
      end else if (regHit(addrOk_r, addr_r, ADDR_IRQ_MASK)) begin
        irqMask_nxt = hwdata[IRQ_W-1:0];
      end else if (regHit(addrOk_r, addr_r, ADDR_IRQ_STAT)) begin
        irqClr = hwdata[IRQ_W-1:0];
      end
    end
    // a new event wins over a clear in the same cycle
    irqStat_nxt = (irqStat_r & ~irqClr) | irqEvent;
  end
  always_ff @(posedge clock or negedge rstnInt) begin
    if (!rstnInt) begin
      cmdReg_r  <= CMD_RST;
      monSel_r  <= MONSEL_RST;
      decel_r   <= DECEL_RST;
      irqMask_r <= MASK_RST;
      irqStat_r <= '0;
    end else begin
      cmdReg_r  <= cmdReg_nxt;
      monSel_r  <= monSel_nxt;
      decel_r   <= decel_nxt;
      irqMask_r <= irqMask_nxt;
      irqStat_r <= irqStat_nxt;
    end
  end
  assign irq = |(irqStat_r & irqMask_r);

  // per-cycle sampling of command and core status
  logic                eligible;
  logic                reqPause;
  logic                reqCancel;
  logic                pauseEff;
  logic                cancelEff;
  logic                start_nxt;
  logic                discard_nxt;
  logic                stopMode_nxt;
  logic [31:0]         rate_nxt;
  logic [7:0]          code_nxt;
  logic [MONSEL_W-1:0] monEcho_r;
  logic [MONSEL_W-1:0] monEcho_nxt;
  logic                servoReady_r;
  logic                servoReady_nxt;
  logic                energized_r;
  logic                energized_nxt;
  logic                standstill_r;
  logic                standstill_nxt;
  logic                profDone_r;
  logic                profDone_nxt;
  always_comb begin
    eligible  = isMotionCmd(cmdReg_r[CMD_CODE_LSB +: 8]);
    reqPause  = cmdReg_r[PAUSE_REQ_BIT];
    reqCancel = cmdReg_r[CANCEL_REQ_BIT];
    cancelEff = reqCancel && eligible;                          // [RL11] [RL13]
    pauseEff  = reqPause && eligible && !reqCancel;             // [RL5] [RL14]
    state_nxt       = state_r;
    suspendDone_nxt = suspendDone_r;
    abortDone_nxt   = abortDone_r;
    start_nxt       = 1'b0;
    discard_nxt     = 1'b0;
    stopMode_nxt    = stopModeOut;
    rate_nxt        = slowdownRate;
    code_nxt        = activeCommand;
    monEcho_nxt     = monEcho_r;
    servoReady_nxt  = servoReady_r;
    energized_nxt   = energized_r;
    standstill_nxt  = standstill_r;
    profDone_nxt    = profDone_r;
    if (commTick) begin                                         // [RL16]
      stopMode_nxt   = cmdReg_r[STOP_MODE_BIT];                 // [RL7]
      rate_nxt       = decel_r;                                 // [RL7]
      code_nxt       = cmdReg_r[CMD_CODE_LSB +: 8];
      monEcho_nxt    = monSel_r;                                // [RL3]
      servoReady_nxt = servoReadyIn;                            // [RL1]
      energized_nxt  = motorEnergizedIn;                        // [RL2]
      standstill_nxt = standstillFlag;
      profDone_nxt   = profileOutputDone && (state_r != ST_HOLD); // [RL8]
      case (state_r)
        ST_IDLE: begin
          if (eligible && !reqCancel) begin
            state_nxt = ST_RUN;
            start_nxt = 1'b1;
          end
        end
        ST_RUN: begin
          if (cancelEff) begin                                  // [RL14]
            state_nxt   = ST_ABORT;
            discard_nxt = 1'b1;                                 // [RL11]
          end else if (pauseEff) begin
            state_nxt = ST_HOLD;                                // [RL4]
          end else if (!eligible) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (cancelEff) begin                                  // [RL14]
            state_nxt   = ST_ABORT;
            discard_nxt = 1'b1;
          end else if (!reqPause) begin
            state_nxt = ST_RUN;                                 // [RL10]
          end else if (!eligible) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_ABORT: begin
          if (!reqCancel) begin
            state_nxt = eligible ? ST_RUN : ST_IDLE;            // [RL15]
            start_nxt = eligible;                               // [RL15]
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
      suspendDone_nxt = pauseEff && (state_r == ST_HOLD) && standstillFlag;  // [RL8]
      abortDone_nxt   = cancelEff && (state_r == ST_ABORT) &&
                        (positionMode ? profileOutputDone : standstillFlag); // [RL12]
    end
    irqEvent = '0;
    irqEvent[IRQ_SUSPEND_BIT] = suspendDone_nxt && !suspendDone_r;
    irqEvent[IRQ_ABORT_BIT]   = abortDone_nxt && !abortDone_r;
  end
  always_ff @(posedge clock or negedge rstnInt) begin
    if (!rstnInt) begin
      state_r       <= ST_IDLE;
      suspendDone_r <= 1'b0;
      abortDone_r   <= 1'b0;
      motionStart   <= 1'b0;
      motionDiscard <= 1'b0;
      stopModeOut   <= 1'b0;
      slowdownRate  <= DECEL_RST;
      activeCommand <= 8'h00;
      monEcho_r     <= '0;
      servoReady_r  <= 1'b0;
      energized_r   <= 1'b0;
      standstill_r  <= 1'b0;
      profDone_r    <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      suspendDone_r <= suspendDone_nxt;
      abortDone_r   <= abortDone_nxt;
      motionStart   <= start_nxt;
      motionDiscard <= discard_nxt;
      stopModeOut   <= stopMode_nxt;
      slowdownRate  <= rate_nxt;
      activeCommand <= code_nxt;
      monEcho_r     <= monEcho_nxt;
      servoReady_r  <= servoReady_nxt;
      energized_r   <= energized_nxt;
      standstill_r  <= standstill_nxt;
      profDone_r    <= profDone_nxt;
    end
  end
  // halt keeps the motion core's state; discard clears it
  assign motionHalt      = (state_r == ST_HOLD) || (state_r == ST_ABORT); // [RL4] [RL7]
  assign suspendDoneFlag = suspendDone_r;
  assign abortDoneFlag   = abortDone_r;

  // read data
  logic [31:0] statusWord;
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[ST_SUSPEND_DONE_BIT] = suspendDone_r;
    statusWord[ST_ABORT_DONE_BIT]   = abortDone_r;
    statusWord[ST_STANDSTILL_BIT]   = standstill_r;
    statusWord[ST_PROFILE_DONE_BIT] = profDone_r;
    statusWord[ST_SERVO_READY_BIT]  = servoReady_r;                     // [RL1]
    statusWord[ST_ENERGIZED_BIT]    = energized_r;                      // [RL2]
    statusWord[ST_MON1_LSB +: 4]    = monEcho_r[MON1_LSB +: 4];         // [RL3]
    statusWord[ST_MON2_LSB +: 4]    = monEcho_r[MON2_LSB +: 4];         // [RL3]
    statusWord[ST_MON3_LSB +: 4]    = monEcho_r[MON3_LSB +: 4];         // [RL3]
    hrdata = 32'h0000_0000;
    if (regHit(addrOk_r, addr_r, ADDR_CMD)) begin
      hrdata[CMD_W-1:0] = cmdReg_r;
    end else if (regHit(addrOk_r, addr_r, ADDR_MONSEL)) begin
      hrdata[MONSEL_W-1:0] = monSel_r;
    end else if (regHit(addrOk_r, addr_r, ADDR_DECEL)) begin
      hrdata = decel_r;
    end else if (regHit(addrOk_r, addr_r, ADDR_STATUS)) begin
      hrdata = statusWord;
    end else if (regHit(addrOk_r, addr_r, ADDR_IRQ_STAT)) begin
      hrdata[IRQ_W-1:0] = irqStat_r;
    end else if (regHit(addrOk_r, addr_r, ADDR_IRQ_MASK)) begin
      hrdata[IRQ_W-1:0] = irqMask_r;
    end
  end

endmodule : motion_pause_cancel_status

// >>> include/motion_pause_pkg.sv
package motion_pause_pkg;

  // timing
  localparam int CLK_MHZ         = 200;
  localparam int COMM_CYCLE_US   = 1000;
  localparam int COMM_CYCLE_CLKS = COMM_CYCLE_US * CLK_MHZ;

  // register byte offsets
  localparam logic [7:0] ADDR_CMD      = 8'h00;
  localparam logic [7:0] ADDR_MONSEL   = 8'h04;
  localparam logic [7:0] ADDR_DECEL    = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // command register fields
  localparam int CMD_W          = 11;
  localparam int CMD_CODE_LSB   = 0;
  localparam int STOP_MODE_BIT  = 8;
  localparam int PAUSE_REQ_BIT  = 9;
  localparam int CANCEL_REQ_BIT = 10;

  // monitor select fields
  localparam int MONSEL_W = 12;
  localparam int MON1_LSB = 0;
  localparam int MON2_LSB = 4;
  localparam int MON3_LSB = 8;

  // status word fields
  localparam int ST_SUSPEND_DONE_BIT = 0;
  localparam int ST_ABORT_DONE_BIT   = 1;
  localparam int ST_STANDSTILL_BIT   = 2;
  localparam int ST_PROFILE_DONE_BIT = 3;
  localparam int ST_SERVO_READY_BIT  = 12;
  localparam int ST_ENERGIZED_BIT    = 13;
  localparam int ST_MON1_LSB         = 16;
  localparam int ST_MON2_LSB         = 20;
  localparam int ST_MON3_LSB         = 24;

  // interrupt bits
  localparam int IRQ_W           = 2;
  localparam int IRQ_SUSPEND_BIT = 0;
  localparam int IRQ_ABORT_BIT   = 1;

  // reset values
  localparam logic [CMD_W-1:0]    CMD_RST    = 11'h000;
  localparam logic [MONSEL_W-1:0] MONSEL_RST = 12'h000;
  localparam logic [31:0]         DECEL_RST  = 32'h0000_0000;
  localparam logic [IRQ_W-1:0]    MASK_RST   = 2'h0;

  // motion command codes, values arbitrary
  localparam logic [7:0] CMD_TARGET_MOVE      = 8'h01;
  localparam logic [7:0] CMD_JOG_FEED         = 8'h02;
  localparam logic [7:0] CMD_EXT_TRIGGER_JOG  = 8'h03;
  localparam logic [7:0] CMD_EXT_TRIGGER_MOVE = 8'h04;
  localparam logic [7:0] CMD_HOMING           = 8'h05;
  localparam logic [7:0] CMD_SPEED_REGULATION = 8'h06;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01,
    ST_HOLD  = 2'b10,
    ST_ABORT = 2'b11
  } motion_state_t;

endpackage : motion_pause_pkg

// >>> bench/motion_pause_cancel_status_assertions.sv
module motion_pause_cancel_status_assertions #(
  parameter int COMM_CYCLE_CLKS_P = 8
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       rstn,
  // motion core status
  input wire logic       standstillFlag,
  input wire logic       profileOutputDone,
  input wire logic       positionMode,
  // motion core control
  input wire logic       motionStart,
  input wire logic       motionDiscard,
  input wire logic       motionHalt,
  input wire logic [7:0] activeCommand,
  input wire logic       commTick,
  // response flags
  input wire logic       suspendDoneFlag,
  input wire logic       abortDoneFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  import motion_pause_pkg::*;
  logic abortCond;
  assign abortCond = positionMode ? profileOutputDone : standstillFlag;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence s_after_tick;
    $past(commTick);
  endsequence
  sequence s_held_halt;
    motionHalt [*6];
  endsequence
  property p_start; motionStart |-> s_after_tick ##0 !motionHalt; endproperty
  a_start: assert property (p_start) else $error("start pulse off tick or halted");
  property p_discard; motionDiscard |-> s_after_tick ##0 s_held_halt; endproperty
  a_discard: assert property (p_discard) else $error("discard without halt");
  property p_flags_hold; !$past(commTick) |-> $stable({suspendDoneFlag, abortDoneFlag}); endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flag moved off tick");
  property p_sus_halt; suspendDoneFlag |-> motionHalt && !abortDoneFlag; endproperty
  a_sus_halt: assert property (p_sus_halt) else $error("pause done while running");
  property p_sus_still; $rose(suspendDoneFlag) |-> $past(standstillFlag); endproperty
  a_sus_still: assert property (p_sus_still) else $error("pause done while moving");
  property p_abort_cond; $rose(abortDoneFlag) |-> $past(abortCond); endproperty
  a_abort_cond: assert property (p_abort_cond) else $error("cancel done early");
  property p_eligible;
    (suspendDoneFlag || abortDoneFlag) |->
      activeCommand inside {[CMD_TARGET_MOVE:CMD_SPEED_REGULATION]};
  endproperty
  a_eligible: assert property (p_eligible) else $error("done flag on other command");
  property p_halt_tick; $changed(motionHalt) |-> s_after_tick; endproperty
  a_halt_tick: assert property (p_halt_tick) else $error("halt moved off tick");
endmodule : motion_pause_cancel_status_assertions

bind motion_pause_cancel_status motion_pause_cancel_status_assertions #(
  .COMM_CYCLE_CLKS_P(COMM_CYCLE_CLKS_P)
) chk (.clock, .rstn, .standstillFlag, .profileOutputDone, .positionMode, .motionStart,
  .motionDiscard, .motionHalt, .activeCommand, .commTick, .suspendDoneFlag, .abortDoneFlag);

// >>> bench/motion_core_model.sv
module motion_core_model #(
  parameter int FAST = 2,
  parameter int SLOW = 40
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // control from the block; slow comes from the bench
  input  wire logic        motionStart,
  input  wire logic        motionDiscard,
  input  wire logic        motionHalt,
  input  wire logic [31:0] slowdownRate,
  input  wire logic        slow,
  // status to the block
  output logic             standstillFlag,
  output logic             profileOutputDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic runR;
  logic dropR;
  int   haltCnt;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      runR    <= 1'b0;
      dropR   <= 1'b0;
      haltCnt <= 0;
    end else begin
      if (motionStart) begin
        runR  <= 1'b1;
        dropR <= 1'b0;
      end
      if (motionDiscard) dropR <= 1'b1;
      haltCnt <= motionHalt ? haltCnt + 1 : 0;
    end
  end
  // stopping distance grows with the low two bits of the slowdown rate, or is long when slow
  // profile done also shows while halted, so the block must mask it in a pause
  assign standstillFlag = !runR ||
    (motionHalt && haltCnt >= (slow ? SLOW : FAST + int'(slowdownRate[1:0])));
  assign profileOutputDone = standstillFlag && (!runR || dropR || motionHalt);
endmodule : motion_core_model

// >>> bench/motion_pause_cancel_status_bench.sv
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t: got %0h expected %0h", $time, a, e); end end
module motion_pause_cancel_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import motion_pause_pkg::*;
  localparam int COMM = 16;
  logic        clock = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
  logic        servoReadyIn = 1'b0, motorEnergizedIn = 1'b0, positionMode = 1'b0;
  logic [1:0]  htrans = 2'h0, expIrq = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdat, v, hrdata, slowdownRate, decSh = 32'h0;
  logic        hreadyout, hresp, standstillFlag, profileOutputDone, motionStart, irq;
  logic        motionDiscard, motionHalt, stopModeOut, commTick, suspendDoneFlag;
  logic        abortDoneFlag, tickD = 1'b0, el, pa, ca, nS, nA;
  logic        expS = 1'b0, expA = 1'b0, expStart = 1'b0, expDisc = 1'b0;
  logic [7:0]  activeCommand;
  logic [10:0] cmdSh = 11'h0, expCmd = 11'h0;
  logic [31:0] expRate = 32'h0;
  int          n_checks = 0, n_mismatch = 0, st = 0, cyc = 0;

  motion_pause_cancel_status #(.COMM_CYCLE_CLKS_P(COMM)) DUT (.clock, .rstn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .standstillFlag, .profileOutputDone, .servoReadyIn, .motorEnergizedIn, .positionMode,
    .motionStart, .motionDiscard, .motionHalt, .stopModeOut, .slowdownRate, .activeCommand,
    .commTick, .suspendDoneFlag, .abortDoneFlag, .irq);
  motion_core_model core (.clock, .rstn, .motionStart, .motionDiscard, .motionHalt,
    .slowdownRate, .slow, .standstillFlag, .profileOutputDone);

  initial begin
    forever #2.5 clock = ~clock;
  end

  // reference model, stepped once per communication cycle
  always @(posedge clock) begin
    cyc++;
    if (tickD) begin
      `CHK(motionStart, expStart)
      `CHK(motionDiscard, expDisc)
      `CHK(motionHalt, st > 1)
      `CHK(suspendDoneFlag, expS)
      `CHK(abortDoneFlag, expA)
      `CHK({stopModeOut, activeCommand, slowdownRate}, {expCmd[8:0], expRate})
    end
    tickD = 1'b0;
    if (commTick === 1'b1) begin
      el = cmdSh[7:0] inside {[CMD_TARGET_MOVE:CMD_SPEED_REGULATION]};
      pa = cmdSh[PAUSE_REQ_BIT];
      ca = cmdSh[CANCEL_REQ_BIT];
      nS = st == 2 && pa && !ca && el && standstillFlag;
      nA = st == 3 && ca && el && (positionMode ? profileOutputDone : standstillFlag);
      expIrq = expIrq | {nA & ~expA, nS & ~expS};
      expS = nS;
      expA = nA;
      expStart = (st == 0 && el && !ca) || (st == 3 && !ca && el);
      expDisc = (st == 1 || st == 2) && el && ca;
      if (st == 0) st = expStart ? 1 : 0;
      else if (st == 3) st = ca ? 3 : (el ? 1 : 0);
      else st = !el ? 0 : (ca ? 3 : (pa ? 2 : 1));
      expCmd = cmdSh;
      expRate = decSh;
      tickD = 1'b1;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rdat = hrdata;
    if (wr && a == ADDR_CMD) cmdSh <= d[10:0];
    if (wr && a == ADDR_DECEL) decSh <= d;
    if (wr && a == ADDR_IRQ_STAT) expIrq <= expIrq & ~d[1:0];
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    `CHK({hresp, rdat & m}, {1'b0, e & m})
  endtask : rdc

  task automatic ticks(input int n);
    repeat (n) begin
      do @(posedge clock); while (commTick !== 1'b1);
    end
    repeat (2) @(posedge clock);
  endtask : ticks

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    void'($urandom(8347));
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    rdc(ADDR_IRQ_MASK, 32'h0, 32'hFFFF_FFFF);
    rdc(8'h40, 32'h0, 32'hFFFF_FFFF);
    bus(1'b1, ADDR_IRQ_MASK, 32'h3);
    repeat (3) begin
      v = $urandom;
      servoReadyIn     <= v[12];
      motorEnergizedIn <= v[13];
      bus(1'b1, ADDR_MONSEL, {20'h0, v[27:16]});
      bus(1'b1, ADDR_STATUS, ~v);
      ticks(1);
      rdc(ADDR_STATUS, v, 32'h0FFF_3000);
    end
    for (int c = 1; c <= 6; c++) begin
      v = $urandom;
      positionMode <= c[0];
      slow         <= c[1];
      bus(1'b1, ADDR_DECEL, v);
      bus(1'b1, ADDR_CMD, c);
      ticks(2);
      bus(1'b1, ADDR_CMD, 32'h300 | c);
      ticks(5);
      rdc(ADDR_STATUS, 32'h5, 32'hF);
      if (c % 2 == 0) begin
        bus(1'b1, ADDR_CMD, c);
        ticks(2);
      end
      bus(1'b1, ADDR_CMD, 32'h700 | c);
      ticks(5);
      bus(1'b1, ADDR_CMD, c);
      ticks(2);
    end
    bus(1'b1, ADDR_CMD, {24'h7, 8'hF0 | v[7:0]});
    ticks(4);
    rdc(ADDR_IRQ_STAT, {30'h0, expIrq}, 32'h3);
    `CHK(irq, |expIrq)
    bus(1'b1, ADDR_IRQ_MASK, 32'h1);
    @(posedge clock);
    `CHK(irq, expIrq[0])
    bus(1'b1, ADDR_IRQ_STAT, 32'h3);
    @(posedge clock);
    rdc(ADDR_IRQ_STAT, 32'h0, 32'h3);
    `CHK(irq, 1'b0)
    report_and_stop();
  end
endmodule : motion_pause_cancel_status_bench
